// >>> rtl/uart_line_modem_control.sv
`timescale 1ns/1ps
`include "uart_lmc_defines.svh"
module uart_line_modem_control
	import uart_lmc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        serial_in,
	output logic             serial_out,
	input  wire modem_in_s   modem_in,
	output modem_out_s       modem_pins,
	output modem_stat_s      modem_status,
	output logic [7:0]       interrupt_enable,
	input  wire logic        irq_request,
	output logic             irq
);
	top_q_s     q;
	top_q_s     next_q;
	frame_fmt_s fmt;
	logic       tx_busy;
	logic       tx_line;
	logic       loop_on;
	logic       window;
	logic       loop_line;
	logic       rx_line;

	function automatic logic mapped(input logic [5:0] idx);
		mapped = idx == `IDX_DATA || idx == `IDX_IER || idx == `IDX_LFC ||
			idx == `IDX_MLC || idx == `IDX_LSTAT || idx == `IDX_MSTAT;
	endfunction : mapped

	assign fmt     = frame_fmt_s'(q.lfc[5:0]);
	assign loop_on = q.mlc[`MLC_LOOP];
	assign window  = q.lfc[`LFC_WINDOW];
	// The looped line carries break too, so a break can be seen by the own receiver.
	assign loop_line = q.lfc[`LFC_BREAK] ? 1'b0 : tx_line;
	assign rx_line   = loop_on ? loop_line : serial_in;

	char_tx u_tx (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (q.tick),
		.fmt     (fmt),
		.load    (q.tx_load),
		.data    (q.tx_byte),
		.busy    (tx_busy),
		.line    (tx_line)
	);

	always_comb begin
		logic [7:0] rx_cat;
		logic [3:0] nb;
		rx_cat = {rx_line, q.rx_shift[7:1]};
		nb     = data_bits(fmt.wlen);
		next_q = q;

		// Oversampling tick; a zero divisor stops the serial side.
		next_q.tick = 1'b0;
		// A divisor written below the running count must restart it at once; an equality
		// test would let the count run on to wrap-around and stall the line for ages.
		if (q.divisor == 16'h0000 || q.divcnt >= q.divisor - 16'h0001) begin
			next_q.divcnt = 16'h0000;
			next_q.tick   = q.divisor != 16'h0000;
		end else begin
			next_q.divcnt = q.divcnt + 16'h0001;
		end

		// Write path: address and data are taken in either order.
		if (awvalid && q.awready) begin
			next_q.aw_held = 1'b1;
			next_q.aw_idx  = awaddr[7:2];
		end
		if (wvalid && q.wready) begin
			next_q.w_held = 1'b1;
			next_q.wbyte  = wdata[7:0];
			next_q.wstrb0 = wstrb[0];
		end
		if (bready && q.bvalid)
			next_q.bvalid = 1'b0;

		next_q.tx_load = q.tx_pending && !tx_busy && !q.tx_load;
		if (q.tx_load)
			next_q.tx_pending = 1'b0;

		if (q.aw_held && q.w_held && !q.bvalid) begin
			next_q.aw_held = 1'b0;
			next_q.w_held  = 1'b0;
			next_q.bvalid  = 1'b1;
			next_q.bresp   = mapped(q.aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
			if (q.wstrb0) begin
				case (q.aw_idx)
					`IDX_DATA: begin
						if (window) begin
							next_q.divisor[7:0] = q.wbyte;
						end else begin
							next_q.tx_byte    = q.wbyte;
							next_q.tx_pending = 1'b1;
						end
					end
					`IDX_IER: begin
						if (window)
							next_q.divisor[15:8] = q.wbyte;
						else
							next_q.ier = q.wbyte & `IER_MASK;
					end
					`IDX_LFC: next_q.lfc = q.wbyte;
					`IDX_MLC: next_q.mlc = q.wbyte & `MLC_MASK;
					default: ;
				endcase
			end
		end
		next_q.awready = !next_q.aw_held && !next_q.bvalid;
		next_q.wready  = !next_q.w_held && !next_q.bvalid;

		// Read path with its clear-on-read side effects, ahead of the receiver
		// so that a flag set in the same cycle survives the clear.
		if (rready && q.rvalid) begin
			next_q.rvalid  = 1'b0;
			next_q.arready = 1'b1;
		end
		if (arvalid && q.arready) begin
			next_q.rvalid  = 1'b1;
			next_q.arready = 1'b0;
			next_q.rresp   = mapped(araddr[7:2]) ? `RESP_OKAY : `RESP_SLVERR;
			next_q.rdata   = 8'h00;
			case (araddr[7:2])
				`IDX_DATA: begin
					if (window) begin
						next_q.rdata = q.divisor[7:0];
					end else begin
						next_q.rdata    = q.rx_data;
						next_q.rx_ready = 1'b0;
					end
				end
				`IDX_IER: next_q.rdata = window ? q.divisor[15:8] : q.ier;
				`IDX_LFC: next_q.rdata = q.lfc;
				`IDX_MLC: next_q.rdata = q.mlc;
				`IDX_LSTAT: begin
					next_q.rdata = {1'b0, !tx_busy && !q.tx_pending, !q.tx_pending, 1'b0,
						q.frame_err, q.parity_err, q.overrun, q.rx_ready};
					next_q.overrun    = 1'b0;
					next_q.parity_err = 1'b0;
					next_q.frame_err  = 1'b0;
				end
				`IDX_MSTAT: next_q.rdata = {q.mstat, 4'h0};
				default: ;
			endcase
		end

		// Receiver: start bit confirmed at mid-bit, then one sample per bit time.
		if (q.tick) begin
			next_q.rx_ticks = q.rx_ticks + 6'h01;
			unique case (q.rst)
				RX_IDLE: begin
					next_q.rx_ticks = 6'h00;
					if (!rx_line)
						next_q.rst = RX_START;
				end
				RX_START: begin
					if (q.rx_ticks == `MID_TICKS - 6'h01) begin
						next_q.rx_ticks = 6'h00;
						next_q.rx_bitn  = 3'h0;
						next_q.rst      = rx_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (q.rx_ticks == `BIT_TICKS - 6'h01) begin
						next_q.rx_ticks = 6'h00;
						if ({1'b0, q.rx_bitn} == nb - 4'h1) begin
							next_q.rx_shift = rx_cat >> (4'h8 - nb);
							next_q.rst      = fmt.pen ? RX_PARITY : RX_STOP;
						end else begin
							next_q.rx_shift = rx_cat;
							next_q.rx_bitn  = q.rx_bitn + 3'h1;
						end
					end
				end
				RX_PARITY: begin
					if (q.rx_ticks == `BIT_TICKS - 6'h01) begin
						next_q.rx_ticks = 6'h00;
						next_q.rst      = RX_STOP;
						if (rx_line != parity_bit(q.rx_shift, fmt))
							next_q.parity_err = 1'b1;
					end
				end
				RX_STOP: begin
					// Only the first stop bit is checked, as any receiver must.
					if (q.rx_ticks == `BIT_TICKS - 6'h01) begin
						next_q.rst      = RX_IDLE;
						next_q.rx_data  = q.rx_shift;
						next_q.overrun  = next_q.overrun | next_q.rx_ready;
						next_q.rx_ready = 1'b1;
						if (!rx_line)
							next_q.frame_err = 1'b1;
					end
				end
			endcase
		end

		// Pins and status.
		if (loop_on)
			next_q.sout = 1'b1;
		else
			next_q.sout = q.lfc[`LFC_BREAK] ? 1'b0 : tx_line;
		if (loop_on) begin
			next_q.pins  = 4'hf;
			next_q.mstat = '{dcd: q.mlc[`MLC_OUT2], ri: q.mlc[`MLC_OUT1],
				dsr: q.mlc[`MLC_DTR], cts: q.mlc[`MLC_RTS]};
		end else begin
			next_q.pins  = '{out2_n: 1'b1, out1_n: 1'b1,
				rts_n: !q.mlc[`MLC_RTS], dtr_n: !q.mlc[`MLC_DTR]};
			next_q.mstat = '{dcd: !modem_in.dcd_n, ri: !modem_in.ri_n,
				dsr: !modem_in.dsr_n, cts: !modem_in.cts_n};
		end
		next_q.irq = irq_request && q.mlc[`MLC_OUT2];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q         <= '0;
			q.lfc     <= `LFC_RESET;
			q.mlc     <= `MLC_RESET;
			q.divisor <= `DIV_RESET;
			q.awready <= 1'b1;
			q.wready  <= 1'b1;
			q.arready <= 1'b1;
			q.rst     <= RX_IDLE;
			q.sout    <= 1'b1;
			q.pins    <= 4'hf;
		end else begin
			q <= next_q;
		end
	end

	assign awready          = q.awready;
	assign wready           = q.wready;
	assign bvalid           = q.bvalid;
	assign bresp            = q.bresp;
	assign arready          = q.arready;
	assign rvalid           = q.rvalid;
	assign rresp            = q.rresp;
	assign rdata            = {24'h000000, q.rdata};
	assign serial_out       = q.sout;
	assign modem_pins       = q.pins;
	assign modem_status     = q.mstat;
	assign interrupt_enable = q.ier;
	assign irq              = q.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence div_low_read;
		arvalid && arready && araddr[7:2] == `IDX_DATA && window;
	endsequence

	window_read_a: assert property (
		div_low_read |=> rvalid && rdata[7:0] == $past(q.divisor[7:0]))
		else $error("divisor window read returned wrong byte");

	break_line_a: assert property (
		q.lfc[`LFC_BREAK] && !loop_on |=> !serial_out)
		else $error("break not driven on serial output");

	loop_mark_a: assert property (
		loop_on [*2] |-> serial_out)
		else $error("serial output not marking in loop mode");

	loop_pins_a: assert property (
		loop_on |=> modem_pins == 4'hf)
		else $error("modem pins active in loop mode");

	loop_route_a: assert property (
		loop_on |=> modem_status.dsr == $past(q.mlc[`MLC_DTR]) &&
			modem_status.cts == $past(q.mlc[`MLC_RTS]) &&
			modem_status.dcd == $past(q.mlc[`MLC_OUT2]))
		else $error("loop routing of modem status wrong");

	ring_out1_a: assert property (
		loop_on |=> modem_status.ri == $past(q.mlc[`MLC_OUT1]) && modem_pins.out1_n)
		else $error("auxiliary output one misrouted");

	irq_gate_a: assert property (
		irq |-> $past(irq_request) && $past(q.mlc[`MLC_OUT2]))
		else $error("interrupt passed while gate closed");

	rts_level_a: assert property (
		!loop_on |=> modem_pins.rts_n == !$past(q.mlc[`MLC_RTS]))
		else $error("request-to-send pin level wrong");

	dtr_level_a: assert property (
		!loop_on |=> modem_pins.dtr_n == !$past(q.mlc[`MLC_DTR]))
		else $error("data-terminal-ready pin level wrong");

	irq_pass_a: assert property (
		irq_request && q.mlc[`MLC_OUT2] |=> irq)
		else $error("interrupt blocked while gate open");

	window_write_a: assert property (
		q.aw_held && q.w_held && !q.bvalid && q.wstrb0 && q.aw_idx == `IDX_IER && window
		|=> q.divisor[15:8] == $past(q.wbyte))
		else $error("divisor high byte not written through window");

	parity_check_a: assert property (
		q.tick && q.rst == RX_PARITY && q.rx_ticks == `BIT_TICKS - 6'h01 &&
			rx_line != parity_bit(q.rx_shift, fmt) |=> q.parity_err)
		else $error("receive parity error not flagged");

	rx_no_parity_a: assert property (
		!fmt.pen && q.rst != RX_PARITY |=> q.rst != RX_PARITY)
		else $error("receiver entered parity slot with parity disabled");

endmodule : uart_line_modem_control

// >>> rtl/uart_lmc_defines.svh
`ifndef UART_LMC_DEFINES_SVH
`define UART_LMC_DEFINES_SVH

`define IDX_DATA      6'h00
`define IDX_IER       6'h01
`define IDX_LFC       6'h03
`define IDX_MLC       6'h04
`define IDX_LSTAT     6'h05
`define IDX_MSTAT     6'h06

`define LFC_WINDOW    7
`define LFC_BREAK     6
`define MLC_LOOP      4
`define MLC_OUT2      3
`define MLC_OUT1      2
`define MLC_RTS       1
`define MLC_DTR       0

`define LFC_RESET     8'h00
`define MLC_RESET     8'h00
`define MLC_MASK      8'h1f
`define IER_MASK      8'h0f
`define DIV_RESET     16'h0000

`define PTYPE_ODD     2'h0
`define PTYPE_EVEN    2'h1
`define PTYPE_MARK    2'h2
`define PTYPE_SPACE   2'h3

`define BIT_TICKS     6'h10
`define MID_TICKS     6'h08
`define STOP1_TICKS   6'h10
`define STOP15_TICKS  6'h18
`define STOP2_TICKS   6'h20
`define WLEN_BASE     4'h5

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// >>> rtl/uart_lmc_pkg.sv
package uart_lmc_pkg;
`include "uart_lmc_defines.svh"

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;

	typedef struct packed {
		logic [1:0] ptype;
		logic       pen;
		logic       stop2;
		logic [1:0] wlen;
	} frame_fmt_s;

	typedef struct packed {
		logic cts_n;
		logic dsr_n;
		logic dcd_n;
		logic ri_n;
	} modem_in_s;

	typedef struct packed {
		logic out2_n;
		logic out1_n;
		logic rts_n;
		logic dtr_n;
	} modem_out_s;

	typedef struct packed {
		logic dcd;
		logic ri;
		logic dsr;
		logic cts;
	} modem_stat_s;

	typedef struct packed {
		tx_state_e  st;
		logic [7:0] data;
		logic [7:0] shift;
		logic [5:0] ticks;
		logic [2:0] bitn;
		logic       par;
		logic       line;
		logic       busy;
	} tx_q_s;

	typedef struct packed {
		logic [7:0]  lfc;
		logic [7:0]  mlc;
		logic [7:0]  ier;
		logic [15:0] divisor;
		logic [15:0] divcnt;
		logic        tick;
		logic        aw_held;
		logic        w_held;
		logic [5:0]  aw_idx;
		logic [7:0]  wbyte;
		logic        wstrb0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [7:0]  rdata;
		logic [1:0]  rresp;
		logic        tx_pending;
		logic        tx_load;
		logic [7:0]  tx_byte;
		rx_state_e   rst;
		logic [5:0]  rx_ticks;
		logic [2:0]  rx_bitn;
		logic [7:0]  rx_shift;
		logic [7:0]  rx_data;
		logic        rx_ready;
		logic        overrun;
		logic        parity_err;
		logic        frame_err;
		logic        sout;
		modem_out_s  pins;
		modem_stat_s mstat;
		logic        irq;
	} top_q_s;

	function automatic logic [3:0] data_bits(input logic [1:0] wlen);
		data_bits = `WLEN_BASE + {2'h0, wlen};
	endfunction : data_bits

	function automatic logic [5:0] stop_ticks(input frame_fmt_s f);
		if (!f.stop2)
			stop_ticks = `STOP1_TICKS;
		else if (f.wlen == 2'h0)
			stop_ticks = `STOP15_TICKS;
		else
			stop_ticks = `STOP2_TICKS;
	endfunction : stop_ticks

	function automatic logic parity_bit(input logic [7:0] d, input frame_fmt_s f);
		logic x;
		x = ^(d & (8'hff >> (2'h3 - f.wlen)));
		case (f.ptype)
			`PTYPE_ODD:  parity_bit = ~x;
			`PTYPE_EVEN: parity_bit = x;
			`PTYPE_MARK: parity_bit = 1'b1;
			default:     parity_bit = 1'b0;
		endcase
	endfunction : parity_bit

endpackage : uart_lmc_pkg

// >>> rtl/char_tx.sv
`timescale 1ns/1ps
`include "uart_lmc_defines.svh"
module char_tx
	import uart_lmc_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       tick,
	input  wire frame_fmt_s fmt,
	input  wire logic       load,
	input  wire logic [7:0] data,
	output logic            busy,
	output logic            line
);
	tx_q_s q;
	tx_q_s next_q;

	always_comb begin
		next_q = q;
		unique case (q.st)
			TX_IDLE: begin
				if (load) begin
					next_q.st    = TX_START;
					next_q.data  = data;
					next_q.shift = data;
					next_q.ticks = 6'h00;
					next_q.par   = parity_bit(data, fmt);
					next_q.line  = 1'b0;
					next_q.busy  = 1'b1;
				end
			end
			TX_START: begin
				if (tick) begin
					next_q.ticks = q.ticks + 6'h01;
					if (q.ticks == `BIT_TICKS - 6'h01) begin
						next_q.st    = TX_DATA;
						next_q.ticks = 6'h00;
						next_q.bitn  = 3'h0;
						next_q.line  = q.shift[0];
					end
				end
			end
			TX_DATA: begin
				if (tick) begin
					next_q.ticks = q.ticks + 6'h01;
					if (q.ticks == `BIT_TICKS - 6'h01) begin
						next_q.ticks = 6'h00;
						if ({1'b0, q.bitn} == data_bits(fmt.wlen) - 4'h1) begin
							next_q.st   = fmt.pen ? TX_PARITY : TX_STOP;
							next_q.line = fmt.pen ? q.par : 1'b1;
						end else begin
							next_q.shift = {1'b0, q.shift[7:1]};
							next_q.bitn  = q.bitn + 3'h1;
							next_q.line  = q.shift[1];
						end
					end
				end
			end
			TX_PARITY: begin
				if (tick) begin
					next_q.ticks = q.ticks + 6'h01;
					if (q.ticks == `BIT_TICKS - 6'h01) begin
						next_q.st    = TX_STOP;
						next_q.ticks = 6'h00;
						next_q.line  = 1'b1;
					end
				end
			end
			TX_STOP: begin
				if (tick) begin
					next_q.ticks = q.ticks + 6'h01;
					// Half-bit steps of the 16x tick give the 1.5 stop-bit case.
					if (q.ticks == stop_ticks(fmt) - 6'h01) begin
						next_q.st   = TX_IDLE;
						next_q.busy = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q      <= '0;
			q.st   <= TX_IDLE;
			q.line <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign busy = q.busy;
	assign line = q.line;

	sequence data_to_parity;
		q.st == TX_DATA ##1 q.st == TX_PARITY;
	endsequence

	parity_slot_a: assert property (@(posedge aclk) disable iff (!aresetn)
		data_to_parity |-> $past(fmt.pen))
		else $error("parity slot sent while parity is disabled");

	parity_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
		q.st == TX_PARITY |-> q.line == parity_bit(q.data, fmt))
		else $error("parity bit value wrong");

	word_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
		q.st == TX_DATA ##1 q.st != TX_DATA
		|-> $past({1'b0, q.bitn}) == data_bits(fmt.wlen) - 4'h1)
		else $error("wrong number of data bits");

	stop_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
		q.st == TX_STOP ##1 q.st == TX_IDLE
		|-> $past(q.ticks) + 6'h01 == stop_ticks(fmt) && q.line)
		else $error("stop time wrong");

endmodule : char_tx

// >>> verif/modem_model.sv
`timescale 1ns/1ps
// Data set that echoes our transmit line back after a lag chosen by the bench.
module modem_model
	import uart_lmc_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       tx_line,
	input  wire logic [2:0] lag,
	input  wire logic       jam,
	output modem_in_s       modem_in,
	output logic            serial_in
);
	logic [7:0] hist = 8'hff;

	// Only clear-to-send is asserted, so loopback routing shows up as a change.
	assign modem_in = 4'h7;
	// A jammed line sits at spacing, which corrupts any receiver still listening.
	assign serial_in = jam ? 1'b0 : hist[lag];

	always_ff @(posedge aclk) begin
		hist <= {hist[6:0], tx_line};
	end
endmodule : modem_model

// >>> verif/uart_line_modem_control_tb.sv
`timescale 1ns/1ps
module uart_line_modem_control_tb
	import uart_lmc_pkg::*;
;
	typedef struct {
		logic [7:0] wa, d, ra, rd;
		logic [1:0] resp;
		logic [3:0] pins, stat;
		logic       irq;
	} row_s;

	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h1;
	logic        irq_request = 1'b0, jam = 1'b0;
	logic [2:0]  lag = 3'h0;
	logic        awready, wready, bvalid, arready, rvalid, serial_in, serial_out, irq;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata;
	logic [7:0]  interrupt_enable, got;
	modem_in_s   modem_in;
	modem_out_s  modem_pins;
	modem_stat_s modem_status;
	int          cyc = 0, mismatches = 0, checks_done = 0;

	row_s rows [17] = '{
		'{8'h0c, 8'h80, 8'h0c, 8'h80, 2'h0, 4'hf, 4'h1, 1'b0},
		'{8'h00, 8'h34, 8'h00, 8'h34, 2'h0, 4'hf, 4'h1, 1'b0},
		'{8'h04, 8'h12, 8'h04, 8'h12, 2'h0, 4'hf, 4'h1, 1'b0},
		'{8'h0c, 8'h00, 8'h0c, 8'h00, 2'h0, 4'hf, 4'h1, 1'b0},
		'{8'h04, 8'h0a, 8'h04, 8'h0a, 2'h0, 4'hf, 4'h1, 1'b0},
		'{8'h0c, 8'h80, 8'h04, 8'h12, 2'h0, 4'hf, 4'h1, 1'b0},
		'{8'h0c, 8'h00, 8'h04, 8'h0a, 2'h0, 4'hf, 4'h1, 1'b0},
		'{8'h10, 8'h01, 8'h10, 8'h01, 2'h0, 4'he, 4'h1, 1'b0},
		'{8'h10, 8'h02, 8'h10, 8'h02, 2'h0, 4'hd, 4'h1, 1'b0},
		'{8'h10, 8'h04, 8'h10, 8'h04, 2'h0, 4'hf, 4'h1, 1'b0},
		'{8'h10, 8'hef, 8'h10, 8'h0f, 2'h0, 4'hc, 4'h1, 1'b1},
		'{8'h10, 8'h1f, 8'h10, 8'h1f, 2'h0, 4'hf, 4'hf, 1'b1},
		'{8'h10, 8'h11, 8'h10, 8'h11, 2'h0, 4'hf, 4'h2, 1'b0},
		'{8'h10, 8'h16, 8'h10, 8'h16, 2'h0, 4'hf, 4'h5, 1'b0},
		'{8'h10, 8'h18, 8'h10, 8'h18, 2'h0, 4'hf, 4'h8, 1'b1},
		'{8'h10, 8'h00, 8'h10, 8'h00, 2'h0, 4'hf, 4'h1, 1'b0},
		'{8'h1c, 8'h55, 8'h1c, 8'h00, 2'h2, 4'hf, 4'h1, 1'b0}
	};
	logic [7:0] fmts [8] = '{8'h00, 8'h04, 8'h0d, 8'h1a, 8'h2b, 8'h3f, 8'h33, 8'h27};

	uart_line_modem_control dut_u (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .serial_in(serial_in),
		.serial_out(serial_out), .modem_in(modem_in), .modem_pins(modem_pins),
		.modem_status(modem_status), .interrupt_enable(interrupt_enable),
		.irq_request(irq_request), .irq(irq)
	);

	modem_model peer_u (
		.aclk(aclk), .tx_line(serial_out), .lag(lag), .jam(jam),
		.modem_in(modem_in), .serial_in(serial_in)
	);

	always #5 aclk = ~aclk;

	// A hung handshake ends the run here instead of spinning forever.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] resp);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata[7:0];
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic level(input logic v, input int n);
		int bad;
		bad = 0;
		repeat (n) begin
			@(posedge aclk);
			if (serial_out !== v)
				bad++;
		end
		chk(bad, 0);
	endtask : level

	task automatic wait_low(output int t);
		do @(posedge aclk); while (serial_out !== 1'b0);
		t = cyc;
	endtask : wait_low

	function automatic logic par(input logic [7:0] d, input logic [7:0] f);
		logic x;
		x = ^(d & (8'hff >> (3 - f[1:0])));
		case (f[5:4])
			2'h0: par = ~x;
			2'h1: par = x;
			default: par = ~f[4];
		endcase
	endfunction : par

	// Two characters back to back, so the stop time shows as the gap between start bits.
	task automatic frame(input logic [7:0] f, input logic [7:0] d);
		int n, p, stp, t0, t1, k, base;
		logic [11:0] bits;
		logic [1:0] rr;
		n = 5 + f[1:0];
		p = f[3];
		stp = !f[2] ? 16 : (n == 5 ? 24 : 32);
		base = 16 * (1 + n + p) + stp;
		bits = 12'hffe;
		for (k = 0; k < n; k++)
			bits[k + 1] = d[k];
		if (p)
			bits[n + 1] = par(d, f);
		wr(8'h0c, f, rr);
		wr(8'h00, d, rr);
		wait_low(t0);
		fork
			for (k = 0; k <= n + p + 1; k++) begin
				repeat (k == 0 ? 8 : 16) @(posedge aclk);
				chk(serial_out, bits[k]);
			end
			wr(8'h00, d, rr);
		join
		wait_low(t1);
		chk(t1 - t0 >= base && t1 - t0 <= base + 3, 1'b1);
		repeat (base + 60) @(posedge aclk);
		rd(8'h00, got, rr);
		chk(got, d & (8'hff >> (3 - f[1:0])));
		rd(8'h14, got, rr);
		chk(got & 8'h0c, 8'h00);
	endtask : frame

	initial begin
		int t0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h0c, got, r);
		chk(got, 8'h00);
		rd(8'h10, got, r);
		chk(got, 8'h00);
		chk(modem_pins, 4'hf);
		chk(serial_out, 1'b1);
		chk(irq, 1'b0);
		$display("test reset done");
		irq_request <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].d, r);
			chk(r, rows[i].resp);
			rd(rows[i].ra, got, r);
			chk(r, rows[i].resp);
			chk(got, rows[i].rd);
			chk(modem_pins, rows[i].pins);
			chk(modem_status, rows[i].stat);
			chk(irq, rows[i].irq);
		end
		chk(interrupt_enable, 8'h0a);
		$display("test registers done");
		wr(8'h0c, 8'h80, r);
		wr(8'h00, 8'h01, r);
		wr(8'h04, 8'h00, r);
		foreach (fmts[i]) begin
			lag <= 3'(i);
			frame(fmts[i], 8'hb3);
		end
		// A jam over the echoed mark parity bit only must flag parity and not framing.
		wr(8'h0c, 8'h2b, r);
		wr(8'h00, 8'h3c, r);
		wait_low(t0);
		repeat (148) @(posedge aclk);
		jam <= 1'b1;
		repeat (17) @(posedge aclk);
		jam <= 1'b0;
		repeat (200) @(posedge aclk);
		rd(8'h14, got, r);
		chk(got & 8'h0c, 8'h04);
		$display("test frames done");
		wr(8'h0c, 8'h43, r);
		wr(8'h00, 8'hff, r);
		level(1'b0, 64);
		wr(8'h0c, 8'h03, r);
		repeat (200) @(posedge aclk);
		level(1'b1, 8);
		$display("test break done");
		jam <= 1'b1;
		wr(8'h10, 8'h10, r);
		wr(8'h00, 8'h5a, r);
		level(1'b1, 200);
		rd(8'h00, got, r);
		chk(got, 8'h5a);
		jam <= 1'b0;
		wr(8'h10, 8'h08, r);
		irq_request <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		$display("test loop done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h10, got, r);
		chk(got, 8'h00);
		chk(modem_pins, 4'hf);
		$display("test second reset done");
		summarize();
	end
endmodule : uart_line_modem_control_tb
